// ===== src/lcpt_top.sv
// three-channel led turn-on delay, pulse chopper and safety gating
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "lcpt_params.svh"

// Contract
// R1 - 10-bit turn-on delay counts timer ticks
// R2 - on rise, count down; drive at zero
// R3 - on fall switches output off at once
// R4 - delay clock divides by 1 to 128
// R5 - delay count captured at on rise
// R6 - zero delay count bypasses the delay
// R7 - timers use internal or external clock
// R8 - delay behaves the same in all loop modes
// R9 - two 10-bit counters alternate on/off phases
// R10 - controller keeps pulse divider at least 8; not enforced here, and the bench chops at divide by 1
// R11 - release feedback during pulse-off when configured
// R12 - pulse counts captured at on rise
// R13 - zero pulse count disables chopping
// R14 - shutdown rise cuts drive, enters low power
// R15 - current msbs above threshold raise alarm
// R16 - alarms sticky until write-one clear
// R17 - auto shutdown forces dac input zero
// R18 - output-disable field turns outputs off
// R19 - low pin voltage flags channel fault
// R20 - three fault flags readable, not read-cleared
// R21 - fault assertion delayed after turn-on
// R22 - fault detectors set up per channel
// R23 - delay codes 50/100/200/500 us
// R24 - chopping starts with on phase after delay
// R25 - enable is on input gated and masked
module lcpt_top #(
  parameter int FAULT_CYC_200 = `LCPT_FAULT_US_200 * `LCPT_CLK_MHZ,
  parameter int FAULT_CYC_500 = `LCPT_FAULT_US_500 * `LCPT_CLK_MHZ
) (
  input wire logic CLK,
  input wire logic RST,
  input wire lcpt_pkg::lcpt_ahb_req_type AHB_REQ,
  output lcpt_pkg::lcpt_ahb_rsp_type AHB_RSP,
  input wire logic [2:0] CHANNEL_ON_INPUT,
  input wire logic EXT_CLK_IN,
  input wire logic SHUTDOWN_PIN,
  input wire logic [2:0] PIN_BELOW_THRESHOLD,
  output logic [2:0] CURRENT_ENABLE,
  output logic [2:0] DAC_FORCE_ZERO,
  output logic [2:0] FEEDBACK_RELEASE,
  output logic DRIVE_TENTH,
  output logic LOW_POWER
);
  import lcpt_pkg::*;

  localparam logic [13:0] FCYC_50 = 14'(`LCPT_FAULT_US_50 * `LCPT_CLK_MHZ);
  localparam logic [13:0] FCYC_100 = 14'(`LCPT_FAULT_US_100 * `LCPT_CLK_MHZ);
  localparam logic [13:0] FCYC_200 = 14'(FAULT_CYC_200);
  localparam logic [13:0] FCYC_500 = 14'(FAULT_CYC_500);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // divider code to prescaler mask; codes above 7 saturate at 128
  function automatic logic [6:0] div_mask(input logic [3:0] code);
    logic [2:0] sh;
    sh = code[3] ? 3'h0 : 3'(3'h7 - code[2:0]);
    div_mask = 7'h7F >> sh;
  endfunction : div_mask

  function automatic logic [7:0] ch_addr(input logic [7:0] base, input int c);
    ch_addr = base + 8'({c[1:0], 2'h0});
  endfunction : ch_addr

  function automatic logic [13:0] fault_cyc(input logic [1:0] code);
    case (code)
      2'h3: fault_cyc = FCYC_50; // R23
      2'h2: fault_cyc = FCYC_100;
      2'h1: fault_cyc = FCYC_200;
      default: fault_cyc = FCYC_500;
    endcase
  endfunction : fault_cyc

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [31:0] hrdata_ff;
  logic hready_ff;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic hit_ff;
  logic [7:0] addr_ff;
  logic [31:0] nxt_rdata;
  logic addr_take;

  assign addr_take = AHB_REQ.hsel & AHB_REQ.htrans[1] & AHB_REQ.hready;
  assign AHB_RSP = '{hrdata: hrdata_ff, hreadyout: hready_ff, hresp: 1'b0};

  // reads take one wait state so a preceding write is always visible
  always_ff @(posedge CLK) begin
    if (RST) begin
      hrdata_ff <= 32'h0;
      hready_ff <= 1'b1;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      hit_ff <= 1'b0;
      addr_ff <= 8'h0;
    end else begin
      wr_pend_ff <= addr_take & AHB_REQ.hwrite;
      if (addr_take) begin
        addr_ff <= AHB_REQ.haddr[7:0];
        hit_ff <= (AHB_REQ.haddr[31:8] == 24'h0);
      end
      if (addr_take & ~AHB_REQ.hwrite) begin
        hready_ff <= 1'b0;
        rd_pend_ff <= 1'b1;
      end else if (rd_pend_ff) begin
        hready_ff <= 1'b1;
        rd_pend_ff <= 1'b0;
        hrdata_ff <= nxt_rdata;
      end
    end
  end

  logic wr;
  logic [31:0] wd;
  assign wr = wr_pend_ff & hit_ff;
  assign wd = AHB_REQ.hwdata;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [7:0] cfg_first_ff;
  logic [7:0] cfg_second_ff;
  logic [7:0] clk_div_ff;
  logic [7:0] clk_ctrl_ff;
  logic [7:0] fsetup_lo_ff;
  logic [7:0] fsetup_hi_ff;
  logic [9:0] dly_ff [3];
  logic [9:0] pulse_high_count_ff [3];
  logic [9:0] pulse_low_count_ff [3];
  logic [7:0] thr_ff [3];
  logic [9:0] iout_ff [3];

  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_first_ff <= 8'h0;
      cfg_second_ff <= 8'h0;
      clk_div_ff <= 8'h0;
      clk_ctrl_ff <= 8'h0;
      fsetup_lo_ff <= `LCPT_RST_FSETUP_LO;
      fsetup_hi_ff <= `LCPT_RST_FSETUP_HI;
      for (int c = 0; c < 3; c++) begin
        dly_ff[c] <= 10'h0;
        pulse_high_count_ff[c] <= 10'h0;
        pulse_low_count_ff[c] <= 10'h0;
        thr_ff[c] <= `LCPT_RST_THRESH;
        iout_ff[c] <= 10'h0;
      end
    end else if (wr) begin
      if (addr_ff == `LCPT_OFF_CFG_FIRST) cfg_first_ff <= wd[7:0];
      if (addr_ff == `LCPT_OFF_CFG_SECOND) cfg_second_ff <= wd[7:0];
      if (addr_ff == `LCPT_OFF_CLK_DIV) clk_div_ff <= wd[7:0];
      if (addr_ff == `LCPT_OFF_CLK_CTRL) clk_ctrl_ff <= wd[7:0];
      if (addr_ff == `LCPT_OFF_FSETUP_LO) fsetup_lo_ff <= wd[7:0]; // R22
      if (addr_ff == `LCPT_OFF_FSETUP_HI) fsetup_hi_ff <= wd[7:0]; // R22
      for (int c = 0; c < 3; c++) begin
        if (addr_ff == ch_addr(`LCPT_OFF_DELAY, c)) dly_ff[c] <= wd[9:0];
        if (addr_ff == ch_addr(`LCPT_OFF_HIGH, c)) pulse_high_count_ff[c] <= wd[9:0];
        if (addr_ff == ch_addr(`LCPT_OFF_LOW, c)) pulse_low_count_ff[c] <= wd[9:0];
        if (addr_ff == ch_addr(`LCPT_OFF_THRESH, c)) thr_ff[c] <= wd[7:0];
        if (addr_ff == ch_addr(`LCPT_OFF_IOUT, c)) iout_ff[c] <= wd[9:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // timer clock source and dividers
  // ----------------------------------------------------------------
  logic ext_prev_ff;
  logic [6:0] pre_ff;
  logic base_tick;
  logic tick_dly;
  logic tick_pls;

  // the external clock must stay well below CLK since it is edge-sampled
  assign base_tick = clk_ctrl_ff[`LCPT_BIT_EXT_CLK] ? (EXT_CLK_IN & ~ext_prev_ff) : 1'b1; // R7
  assign tick_dly = base_tick & (&(pre_ff | ~div_mask(clk_div_ff[`LCPT_FLD_DIV_DLY]))); // R4
  assign tick_pls = base_tick & (&(pre_ff | ~div_mask(clk_div_ff[`LCPT_FLD_DIV_PLS])));

  always_ff @(posedge CLK) begin
    if (RST) begin
      ext_prev_ff <= 1'b0;
      pre_ff <= 7'h0;
    end else begin
      ext_prev_ff <= EXT_CLK_IN;
      if (base_tick) pre_ff <= pre_ff + 7'h1;
    end
  end

  // ----------------------------------------------------------------
  // per-channel delay and pulse sequencer
  // ----------------------------------------------------------------
  lcpt_state_type st_ff [3];
  logic [9:0] cnt_ff [3];
  logic [9:0] cap_hi_ff [3];
  logic [9:0] cap_lo_ff [3];
  logic [2:0] chop_ff;
  logic [2:0] on_prev_ff;
  logic [2:0] on_rise;
  logic [2:0] on_fall;

  assign on_rise = CHANNEL_ON_INPUT & ~on_prev_ff;
  assign on_fall = ~CHANNEL_ON_INPUT & on_prev_ff;

  // loop mode is not an input here: delay and chopping ignore it entirely
  always_ff @(posedge CLK) begin
    if (RST) begin
      on_prev_ff <= 3'h0;
      chop_ff <= 3'h0;
      for (int c = 0; c < 3; c++) begin
        st_ff[c] <= LCPT_ST_IDLE;
        cnt_ff[c] <= 10'h0;
        cap_hi_ff[c] <= 10'h0;
        cap_lo_ff[c] <= 10'h0;
      end
    end else begin
      on_prev_ff <= CHANNEL_ON_INPUT;
      for (int c = 0; c < 3; c++) begin
        if (on_fall[c]) begin
          st_ff[c] <= LCPT_ST_IDLE; // R3
        end else if (on_rise[c]) begin
          cap_hi_ff[c] <= pulse_high_count_ff[c]; // R12
          cap_lo_ff[c] <= pulse_low_count_ff[c]; // R12
          chop_ff[c] <= (|pulse_high_count_ff[c]) & (|pulse_low_count_ff[c]); // R13
          if (dly_ff[c] == 10'h0) begin
            st_ff[c] <= LCPT_ST_HIGH; // R6
            cnt_ff[c] <= pulse_high_count_ff[c];
          end else begin
            st_ff[c] <= LCPT_ST_DELAY; // R8
            cnt_ff[c] <= dly_ff[c]; // R5
          end
        end else begin
          case (st_ff[c])
            LCPT_ST_DELAY: begin
              if (tick_dly) begin
                if (cnt_ff[c] == 10'h1) begin
                  st_ff[c] <= LCPT_ST_HIGH; // R24
                  cnt_ff[c] <= cap_hi_ff[c];
                end else begin
                  cnt_ff[c] <= cnt_ff[c] - 10'h1; // R1
                end
              end
            end
            LCPT_ST_HIGH: begin
              if (chop_ff[c] & tick_pls) begin
                if (cnt_ff[c] == 10'h1) begin
                  st_ff[c] <= LCPT_ST_LOW; // R9
                  cnt_ff[c] <= cap_lo_ff[c];
                end else begin
                  cnt_ff[c] <= cnt_ff[c] - 10'h1;
                end
              end
            end
            LCPT_ST_LOW: begin
              if (tick_pls) begin
                if (cnt_ff[c] == 10'h1) begin
                  st_ff[c] <= LCPT_ST_HIGH; // R9
                  cnt_ff[c] <= cap_hi_ff[c];
                end else begin
                  cnt_ff[c] <= cnt_ff[c] - 10'h1;
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output gating and current alarms
  // ----------------------------------------------------------------
  logic [2:0] over;
  logic [2:0] drive;
  logic [2:0] alarm_ff;
  logic sd_prev_ff;
  logic auto_sd;
  logic alarm_clr;

  assign auto_sd = cfg_second_ff[`LCPT_BIT_AUTO_SD];
  assign alarm_clr = wr & (addr_ff == `LCPT_OFF_ALARM) & wd[`LCPT_BIT_ALARM_CLR];

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      over[c] = iout_ff[c][`LCPT_FLD_IOUT_MSB] > thr_ff[c]; // R15
      // a zero delay count drives in the rise cycle itself
      drive[c] = CHANNEL_ON_INPUT[c] // R3
        & ((st_ff[c] == LCPT_ST_HIGH) | (on_rise[c] & (dly_ff[c] == 10'h0))) // R2
        & ~SHUTDOWN_PIN & ~(|cfg_second_ff[`LCPT_FLD_OUT_DIS]) // R18
        & ~(auto_sd & over[c]); // R25
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      CURRENT_ENABLE <= 3'h0;
      DAC_FORCE_ZERO <= 3'h0;
      FEEDBACK_RELEASE <= 3'h0;
      DRIVE_TENTH <= 1'b0;
      LOW_POWER <= 1'b0;
      sd_prev_ff <= 1'b0;
      alarm_ff <= 3'h0;
    end else begin
      CURRENT_ENABLE <= drive; // R25
      DAC_FORCE_ZERO <= {3{auto_sd}} & over; // R17
      for (int c = 0; c < 3; c++) begin
        FEEDBACK_RELEASE[c] <= cfg_first_ff[`LCPT_BIT_FB_RELEASE]
          & (st_ff[c] == LCPT_ST_LOW); // R11
      end
      sd_prev_ff <= SHUTDOWN_PIN;
      DRIVE_TENTH <= SHUTDOWN_PIN; // R14
      if (SHUTDOWN_PIN & ~sd_prev_ff) LOW_POWER <= 1'b1; // R14
      else if (~SHUTDOWN_PIN) LOW_POWER <= 1'b0;
      // a new excess in the clear cycle survives the clear
      alarm_ff <= (alarm_ff & ~{3{alarm_clr}}) | over; // R16
    end
  end

  // ----------------------------------------------------------------
  // led open/short fault detection
  // ----------------------------------------------------------------
  logic [13:0] settle_ff [3];
  logic [2:0] drive_prev_ff;
  logic [2:0] fault_ff;
  logic [2:0] fault_en;
  logic [2:0] fault_clr;

  assign fault_en = ~{fsetup_hi_ff[`LCPT_BIT_PD_CH2], fsetup_lo_ff[`LCPT_BIT_PD_CH1],
                      fsetup_lo_ff[`LCPT_BIT_PD_CH0]}; // R22
  assign fault_clr = {3{wr & (addr_ff == `LCPT_OFF_FSTATUS)}} & wd[2:0];

  always_ff @(posedge CLK) begin
    if (RST) begin
      drive_prev_ff <= 3'h0;
      fault_ff <= 3'h0;
      for (int c = 0; c < 3; c++) settle_ff[c] <= 14'h0;
    end else begin
      drive_prev_ff <= drive;
      for (int c = 0; c < 3; c++) begin
        if (drive[c] & ~drive_prev_ff[c]) begin
          settle_ff[c] <= fault_cyc(fsetup_hi_ff[`LCPT_FLD_FAULT_DLY]); // R21
        end else if (settle_ff[c] != 14'h0) begin
          settle_ff[c] <= settle_ff[c] - 14'h1;
        end
        // driven or not, a low pin means open or short
        fault_ff[c] <= (fault_ff[c] & ~fault_clr[c])
          | (PIN_BELOW_THRESHOLD[c] & fault_en[c] & (settle_ff[c] == 14'h0)); // R19
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0;
    if (hit_ff) begin
      case (addr_ff)
        `LCPT_OFF_CFG_FIRST: nxt_rdata = {24'h0, cfg_first_ff};
        `LCPT_OFF_CFG_SECOND: nxt_rdata = {24'h0, cfg_second_ff};
        `LCPT_OFF_CLK_DIV: nxt_rdata = {24'h0, clk_div_ff};
        `LCPT_OFF_CLK_CTRL: nxt_rdata = {24'h0, clk_ctrl_ff};
        `LCPT_OFF_ALARM: nxt_rdata = {29'h0, alarm_ff}; // R16
        `LCPT_OFF_FSETUP_LO: nxt_rdata = {24'h0, fsetup_lo_ff};
        `LCPT_OFF_FSETUP_HI: nxt_rdata = {24'h0, fsetup_hi_ff};
        `LCPT_OFF_FSTATUS: nxt_rdata = {29'h0, fault_ff}; // R20
        default: begin
          for (int c = 0; c < 3; c++) begin
            if (addr_ff == ch_addr(`LCPT_OFF_DELAY, c)) nxt_rdata = {22'h0, dly_ff[c]};
            if (addr_ff == ch_addr(`LCPT_OFF_HIGH, c))
              nxt_rdata = {22'h0, pulse_high_count_ff[c]};
            if (addr_ff == ch_addr(`LCPT_OFF_LOW, c))
              nxt_rdata = {22'h0, pulse_low_count_ff[c]};
            if (addr_ff == ch_addr(`LCPT_OFF_THRESH, c)) nxt_rdata = {24'h0, thr_ff[c]};
            if (addr_ff == ch_addr(`LCPT_OFF_IOUT, c)) nxt_rdata = {22'h0, iout_ff[c]};
          end
        end
      endcase
    end
  end

endmodule : lcpt_top

// ===== src/lcpt_params.svh
// register map, reset values and timing constants of the pulse timer
`ifndef LCPT_PARAMS_SVH
`define LCPT_PARAMS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define LCPT_CLK_MHZ 25

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LCPT_OFF_CFG_FIRST 8'h00
`define LCPT_OFF_CFG_SECOND 8'h04
`define LCPT_OFF_CLK_DIV 8'h08
`define LCPT_OFF_CLK_CTRL 8'h0C
`define LCPT_OFF_DELAY 8'h10
`define LCPT_OFF_HIGH 8'h20
`define LCPT_OFF_LOW 8'h30
`define LCPT_OFF_THRESH 8'h40
`define LCPT_OFF_IOUT 8'h50
`define LCPT_OFF_ALARM 8'h60
`define LCPT_OFF_FSETUP_LO 8'h64
`define LCPT_OFF_FSETUP_HI 8'h68
`define LCPT_OFF_FSTATUS 8'h6C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LCPT_BIT_FB_RELEASE 5
`define LCPT_BIT_AUTO_SD 3
`define LCPT_BIT_EXT_CLK 2
`define LCPT_BIT_ALARM_CLR 0
`define LCPT_BIT_PD_CH0 0
`define LCPT_BIT_PD_CH1 4
`define LCPT_BIT_PD_CH2 0
`define LCPT_FLD_OUT_DIS 1:0
`define LCPT_FLD_DIV_DLY 3:0
`define LCPT_FLD_DIV_PLS 7:4
`define LCPT_FLD_IOUT_MSB 9:2
`define LCPT_FLD_FAULT_DLY 5:4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LCPT_RST_THRESH 8'hFF
`define LCPT_RST_FSETUP_LO 8'h11
`define LCPT_RST_FSETUP_HI 8'h31

// ----------------------------------------------------------------
// fault settling delays in microseconds
// ----------------------------------------------------------------
`define LCPT_FAULT_US_50 50
`define LCPT_FAULT_US_100 100
`define LCPT_FAULT_US_200 200
`define LCPT_FAULT_US_500 500

`endif

// ===== src/lcpt_pkg.sv
// types shared by the pulse timer and its bench
package lcpt_pkg;

  typedef enum logic [1:0] {
    LCPT_ST_IDLE  = 2'h0,
    LCPT_ST_DELAY = 2'h1,
    LCPT_ST_HIGH  = 2'h3,
    LCPT_ST_LOW   = 2'h2
  } lcpt_state_type;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } lcpt_ahb_req_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } lcpt_ahb_rsp_type;

endpackage : lcpt_pkg

// ===== verification/lcpt_ctrl_model.sv
// display controller model driving the per-channel on inputs
`timescale 1ns/1ps
module lcpt_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] want_on,
  output logic [2:0] on_out
);
  // levels move only just after an edge, so every on interval lasts whole cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      on_out <= 3'h0;
    end else begin
      on_out <= want_on;
    end
  end
endmodule : lcpt_ctrl_model

// ===== verification/lcpt_top_asserts.sv
// concurrent checks on the pulse timer top ports
`timescale 1ns/1ps
module lcpt_top_asserts #(
  parameter int FAULT_CYC_200 = 5000,
  parameter int FAULT_CYC_500 = 12500
) (
  input wire logic CLK,
  input wire logic RST,
  input wire lcpt_pkg::lcpt_ahb_req_type AHB_REQ,
  input wire lcpt_pkg::lcpt_ahb_rsp_type AHB_RSP,
  input wire logic [2:0] CHANNEL_ON_INPUT,
  input wire logic EXT_CLK_IN,
  input wire logic SHUTDOWN_PIN,
  input wire logic [2:0] PIN_BELOW_THRESHOLD,
  input wire logic [2:0] CURRENT_ENABLE,
  input wire logic [2:0] DAC_FORCE_ZERO,
  input wire logic [2:0] FEEDBACK_RELEASE,
  input wire logic DRIVE_TENTH,
  input wire logic LOW_POWER
);
  import lcpt_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic taken;
  assign taken = AHB_REQ.hsel && AHB_REQ.htrans[1] && AHB_REQ.hready;
  // ------------
  // bus
  // ------------
  sequence s_one_wait;
    !AHB_RSP.hreadyout ##1 AHB_RSP.hreadyout;
  endsequence
  property p_read_wait;
    taken && !AHB_REQ.hwrite |=> s_one_wait;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read not answered after one wait");
  property p_write_nowait;
    taken && AHB_REQ.hwrite |=> AHB_RSP.hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
  property p_resp_okay;
    AHB_RSP.hresp == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
  // ------------
  // channels
  // ------------
  property p_fall_off;
    (CURRENT_ENABLE & ~$past(CHANNEL_ON_INPUT)) == 3'h0;
  endproperty
  a_fall_off: assert property (p_fall_off) else $error("output on after on fell");
  property p_shut_mask;
    SHUTDOWN_PIN |=> CURRENT_ENABLE == 3'h0;
  endproperty
  a_shut_mask: assert property (p_shut_mask) else $error("drive during shutdown");
  property p_tenth;
    !$past(RST) |-> DRIVE_TENTH == $past(SHUTDOWN_PIN);
  endproperty
  a_tenth: assert property (p_tenth) else $error("reduced drive not one cycle after pin");
  sequence s_shut_rise;
    !SHUTDOWN_PIN ##1 SHUTDOWN_PIN;
  endsequence
  property p_low_power;
    s_shut_rise |=> LOW_POWER;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power not entered");
  property p_low_exit;
    SHUTDOWN_PIN ##1 !SHUTDOWN_PIN |=> !LOW_POWER;
  endproperty
  a_low_exit: assert property (p_low_exit) else $error("low power not left");
  property p_release_off;
    (FEEDBACK_RELEASE & CURRENT_ENABLE) == 3'h0;
  endproperty
  a_release_off: assert property (p_release_off) else $error("release while driven");
  property p_force_zero;
    DAC_FORCE_ZERO[0] ##1 DAC_FORCE_ZERO[0] |-> !CURRENT_ENABLE[0];
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("forced channel still on");
endmodule : lcpt_top_asserts

bind lcpt_top lcpt_top_asserts #(
  .FAULT_CYC_200(FAULT_CYC_200),
  .FAULT_CYC_500(FAULT_CYC_500)
) i_lcpt_top_asserts (
  .CLK, .RST, .AHB_REQ, .AHB_RSP, .CHANNEL_ON_INPUT, .EXT_CLK_IN, .SHUTDOWN_PIN,
  .PIN_BELOW_THRESHOLD, .CURRENT_ENABLE, .DAC_FORCE_ZERO, .FEEDBACK_RELEASE,
  .DRIVE_TENTH, .LOW_POWER
);

// ===== verification/lcpt_top_bench.sv
// self-checking bench for the three-channel led pulse timer
`timescale 1ns/1ps
module lcpt_top_bench;
  import lcpt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lcpt_ahb_req_type req = '0;
  lcpt_ahb_rsp_type rsp;
  logic [2:0] want_on = 3'h0;
  logic [2:0] on_lvl;
  logic ext_clk = 1'b0;
  logic ext_run = 1'b0;
  logic shut = 1'b0;
  logic [2:0] below = 3'h0;
  logic [2:0] en;
  logic [2:0] dfz;
  logic [2:0] fbr;
  logic tenth;
  logic lowp;
  logic [31:0] rd;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 32'h796fb423;
  int n;
  int d;
  int regs[int];
  logic [7:0] adr[9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h40, 8'h48, 8'h64, 8'h68, 8'h7C};
  int fcode[4] = '{1, 0, 3, 2};
  int fcyc[4] = '{20, 40, 1250, 2500};

  always #20 clk = ~clk;
  always @* req.hready = rsp.hreadyout;
  // external timer clock: one rising edge every eight system cycles
  always begin
    repeat (4) @(posedge clk);
    if (ext_run) ext_clk <= ~ext_clk;
  end

  lcpt_ctrl_model i_lcpt_ctrl_model (.clk(clk), .rst(rst), .want_on(want_on), .on_out(on_lvl));
  lcpt_top #(.FAULT_CYC_200(20), .FAULT_CYC_500(40)) i_lcpt_top (
    .CLK(clk), .RST(rst), .AHB_REQ(req), .AHB_RSP(rsp), .CHANNEL_ON_INPUT(on_lvl),
    .EXT_CLK_IN(ext_clk), .SHUTDOWN_PIN(shut), .PIN_BELOW_THRESHOLD(below),
    .CURRENT_ENABLE(en), .DAC_FORCE_ZERO(dfz), .FEEDBACK_RELEASE(fbr),
    .DRIVE_TENTH(tenth), .LOW_POWER(lowp)
  );

  // ------------
  // helpers
  // ------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rng(input int v, input int lo, input int hi);
    n_compared++;
    if (v < lo || v > hi) begin
      num_errors++;
      $display("unexpected at %0t: latency %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask : rng

  // expected turn-on latency for d ticks of a clock divided by k
  task automatic lchk(input int v, input int dl, input int k);
    rng(v, (dl == 0) ? 1 : (dl - 1) * k + 2, (dl == 0) ? 2 : dl * k + 3);
  endtask : lchk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    req.hsel <= 1'b1;
    req.htrans <= 2'h2;
    req.haddr <= {24'h0, a};
    req.hwrite <= wr;
    req.hsize <= 3'h2;
    @(posedge clk);
    while (rsp.hreadyout !== 1'b1) @(posedge clk);
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= wd;
    @(posedge clk);
    while (rsp.hreadyout !== 1'b1) @(posedge clk);
    rd = rsp.hrdata;
    if (wr && a != 8'h60 && a != 8'h6C) regs[a] = wd;
  endtask : bus

  task automatic rchk(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    chk(rd, regs.exists(a) ? regs[a] : 0);
  endtask : rchk

  task automatic lat(input int c);
    want_on[c] <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (en[c] !== 1'b1 && n < 600);
    n = n - 2;
  endtask : lat

  task automatic off(input int c);
    want_on[c] <= 1'b0;
    repeat (3) @(posedge clk);
    chk(en[c], 1'b0);
  endtask : off

  // per = 3 expects a steady output, per = 5 three on and two off
  task automatic pat(input int m, input int per);
    for (int i = 0; i < m; i++) begin
      chk(en[0], (i % per) < 3);
      if (per > 3) chk(fbr[0], (i % per) >= 3);
      @(posedge clk);
    end
  endtask : pat

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  // ------------
  // main sequence
  // ------------
  initial begin
    regs[8'h40] = 8'hFF;
    regs[8'h44] = 8'hFF;
    regs[8'h48] = 8'hFF;
    regs[8'h64] = 8'h11;
    regs[8'h68] = 8'h31;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (adr[i]) rchk(adr[i]);
    for (int i = 0; i < 3; i++) begin
      d = $random(seed) & 32'h3FF;
      bus(1'b1, 8'h10 + 8'(4 * i), d);
      rchk(8'h10 + 8'(4 * i));
    end
    bus(1'b1, 8'h10, 32'h0);
    lat(0);
    lchk(n, 0, 1);
    off(0);
    for (int c = 0; c < 9; c++) begin
      bus(1'b1, 8'h08, c);
      bus(1'b1, 8'h10, 32'h2);
      lat(0);
      lchk(n, 2, 1 << ((c > 7) ? 7 : c));
      off(0);
    end
    bus(1'b1, 8'h08, 32'h0);
    d = 1 + ($random(seed) & 15);
    bus(1'b1, 8'h18, d);
    lat(2);
    lchk(n, d, 1);
    off(2);
    bus(1'b1, 8'h10, 32'd100);
    want_on[0] <= 1'b1;
    bus(1'b1, 8'h10, 32'h0);
    lat(0);
    lchk(n + 2, 100, 1);
    off(0);
    lat(0);
    lchk(n, 0, 1);
    off(0);
    bus(1'b1, 8'h0C, 32'h4);
    bus(1'b1, 8'h10, 32'h3);
    want_on[0] <= 1'b1;
    repeat (40) @(posedge clk);
    chk(en[0], 1'b0);
    ext_run <= 1'b1;
    lat(0);
    rng(n, 14, 34);
    off(0);
    ext_run <= 1'b0;
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b1, 8'h20, 32'h3);
    bus(1'b1, 8'h30, 32'h2);
    bus(1'b1, 8'h00, 32'h20);
    lat(0);
    pat(15, 5);
    bus(1'b1, 8'h30, 32'h0);
    while (en[0] !== 1'b0) @(posedge clk);
    while (en[0] !== 1'b1) @(posedge clk);
    pat(10, 5);
    off(0);
    lat(0);
    pat(10, 3);
    shut <= 1'b1;
    repeat (3) @(posedge clk);
    chk({en[0], tenth, lowp}, 3'b011);
    shut <= 1'b0;
    repeat (3) @(posedge clk);
    chk({en[0], tenth, lowp}, 3'b100);
    for (int c = 1; c < 4; c++) begin
      bus(1'b1, 8'h04, c);
      repeat (2) @(posedge clk);
      chk(en[0], 1'b0);
    end
    bus(1'b1, 8'h04, 32'h0);
    repeat (2) @(posedge clk);
    chk(en[0], 1'b1);
    bus(1'b1, 8'h40, 32'h10);
    bus(1'b1, 8'h50, 32'h3FC);
    bus(1'b0, 8'h60, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, 8'h50, 32'h0);
    bus(1'b0, 8'h60, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, 8'h60, 32'h1);
    bus(1'b0, 8'h60, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h04, 32'h8);
    bus(1'b1, 8'h50, 32'h3FC);
    repeat (2) @(posedge clk);
    chk({dfz[0], en[0]}, 2'b10);
    bus(1'b1, 8'h50, 32'h0);
    bus(1'b1, 8'h04, 32'h0);
    off(0);
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, 8'h64, 32'h0);
      bus(1'b1, 8'h68, fcode[j] << 4);
      lat(0);
      below <= 3'h1;
      repeat (fcyc[j] / 2) @(posedge clk);
      bus(1'b0, 8'h6C, 32'h0);
      chk(rd, 32'h0);
      repeat (fcyc[j]) @(posedge clk);
      bus(1'b0, 8'h6C, 32'h0);
      chk(rd, 32'h1);
      bus(1'b0, 8'h6C, 32'h0);
      chk(rd, 32'h1);
      below <= 3'h0;
      bus(1'b1, 8'h6C, 32'h1);
      bus(1'b0, 8'h6C, 32'h0);
      chk(rd, 32'h0);
      off(0);
    end
    stop_test();
  end
endmodule : lcpt_top_bench
